//--- brake_model.sv
// Model of a mechanical brake worked by one output terminal.
`timescale 1ns/100ps
module brake_model #(
   parameter int ENGAGE_CYCLES = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic apply_cmd,
   output logic engaged
);
   int cnt;
   // A real brake needs time to close, so engagement lags the command.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         engaged <= 1'b0;
      end else begin
         cnt <= !apply_cmd ? 0 : (cnt < ENGAGE_CYCLES ? cnt + 1 : cnt);
         engaged <= apply_cmd && (cnt >= ENGAGE_CYCLES);
      end
   end
endmodule

//--- ct_monitor.sv
// Concurrent checks on the ports of the current and torque detectors.
`timescale 1ns/100ps
module ct_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hwdata,
   input wire current_torque_pkg::meas_t meas,
   input wire current_torque_pkg::drive_state_t drive,
   input wire logic overcurrent_detect_flag,
   input wire logic zero_current_flag,
   input wire logic torque_reached_flag,
   input wire logic current_detect_fault
);
   // =====================================================
   // Properties
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   tq_vf_block_a: assert property (drive.vf_control |=> !torque_reached_flag)
      else $error("torque flag raised under plain control");
   tq_full_scale_a: assert property (!drive.vf_control &&
      meas.torque == 16'hffff |=> torque_reached_flag)
      else $error("torque flag missing at full scale torque");
   tq_rise_cause_a: assert property ($rose(torque_reached_flag) |->
      !$past(drive.vf_control)) else $error("torque flag rose under plain control");
   zc_min_on_a: assert property ($rose(zero_current_flag) |=>
      zero_current_flag [*8]) else $error("zero current flag too short");
   zc_off_hold_a: assert property ($fell(zero_current_flag) |=>
      !zero_current_flag [*8]) else $error("zero current flag chatters");
   oc_publish_hold_a: assert property ($rose(overcurrent_detect_flag) |=>
      overcurrent_detect_flag [*8]) else $error("overcurrent flag too short");
   fault_clear_cause_a: assert property ($fell(current_detect_fault) |->
      $past(hwdata[3])) else $error("fault cleared without a clear write");
   fault_set_cause_a: assert property ($rose(current_detect_fault) |->
      $past(overcurrent_detect_flag || zero_current_flag))
      else $error("fault set without a detect flag");
   cover property ($rose(current_detect_fault));
   cover property ($rose(zero_current_flag));
   cover property ($rose(overcurrent_detect_flag));
endmodule

bind current_torque_threshold_detect ct_monitor i_mon (.hclk(hclk),
   .hresetn(hresetn), .hwdata(hwdata), .meas(meas), .drive(drive),
   .overcurrent_detect_flag(overcurrent_detect_flag),
   .zero_current_flag(zero_current_flag),
   .torque_reached_flag(torque_reached_flag),
   .current_detect_fault(current_detect_fault));

//--- current_torque_pkg.sv
// Constants, register map and carrier types for the current and torque detectors.
package current_torque_pkg;

   // ==========================================================================
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int RESPONSE_MS = 100;
   localparam int UPDATE_TICKS = RESPONSE_MS / TICK_MS;
   localparam int ZC_MIN_ON_MS = 100;
   localparam int ZC_OFF_MS = 100;
   localparam logic [15:0] ZC_MIN_ON_TICKS = 16'(ZC_MIN_ON_MS / TICK_MS);
   localparam logic [15:0] ZC_OFF_TICKS = 16'(ZC_OFF_MS / TICK_MS);

   // ==========================================================================
   // Setting ranges and reset values (levels in 0.1 %, times in ticks)
   localparam logic [15:0] LEVEL_MAX = 16'h0fa0;
   localparam logic [15:0] TIME_MAX = 16'h03e8;
   localparam logic [15:0] HOLD_FOREVER = 16'h270f;
   localparam logic [15:0] OC_LEVEL_RST = 16'h05dc;
   localparam logic [15:0] OC_DELAY_RST = 16'h0000;
   localparam logic [15:0] ZC_LEVEL_RST = 16'h0032;
   localparam logic [15:0] ZC_TIME_RST = 16'h0032;
   localparam logic [15:0] OC_HOLD_RST = 16'h000a;
   localparam logic [15:0] TQ_LEVEL_RST = 16'h05dc;
   localparam logic [7:0] TRIP_RST = 8'h00;
   localparam logic [7:0] FUNC_RST = 8'h00;

   // ==========================================================================
   // Trip selection and terminal function codes
   localparam logic [7:0] TRIP_OC = 8'h01;
   localparam logic [7:0] TRIP_ZC = 8'h0a;
   localparam logic [7:0] TRIP_BOTH = 8'h0b;
   localparam logic [7:0] FUNC_OC_POS = 8'h0c;
   localparam logic [7:0] FUNC_OC_NEG = 8'h70;
   localparam logic [7:0] FUNC_ZC_POS = 8'h0d;
   localparam logic [7:0] FUNC_ZC_NEG = 8'h71;
   localparam logic [7:0] FUNC_TQ_POS = 8'h23;
   localparam logic [7:0] FUNC_TQ_NEG = 8'h87;

   // ==========================================================================
   // Register byte offsets
   localparam logic [7:0] TRIP_SELECT_OFS = 8'h00;
   localparam logic [7:0] OC_LEVEL_OFS = 8'h04;
   localparam logic [7:0] OC_DELAY_OFS = 8'h08;
   localparam logic [7:0] ZC_LEVEL_OFS = 8'h0c;
   localparam logic [7:0] ZC_TIME_OFS = 8'h10;
   localparam logic [7:0] OC_HOLD_OFS = 8'h14;
   localparam logic [7:0] TQ_LEVEL_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1c;
   localparam logic [7:0] TERM_FUNC_OFS = 8'h20;
   localparam int ST_OC_BIT = 0;
   localparam int ST_ZC_BIT = 1;
   localparam int ST_TQ_BIT = 2;
   localparam int ST_FAULT_BIT = 3;

   // ==========================================================================
   // Carrier types
   typedef struct packed {
      logic [15:0] current;
      logic [15:0] torque;
   } meas_t;

   typedef struct packed {
      logic running;
      logic start;
      logic vf_control;
      logic autotuning;
   } drive_state_t;

endpackage

//--- current_torque_threshold_detect.sv
// Current and torque threshold detectors with an AHB-Lite register slave.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps

// Behaviour
// RULE_01: Compare output current with an overcurrent level, 0 to 400 %, default 150 %.
// RULE_02: Overcurrent flag sets after current stays above level for the delay.
// RULE_03: Overcurrent flag, once on, stays on for the programmed hold time.
// RULE_04: Hold setting 9999 keeps the overcurrent flag on until next start.
// RULE_05: Trip selection 0, 1, 10, 11 chooses which flags raise the fault.
// RULE_06: Trip selection change takes effect only once that flag is off.
// RULE_07: Function code 12 or 112 puts the overcurrent flag on a terminal.
// RULE_08: Compare output current with a zero-current level, default 5 %.
// RULE_09: Zero-current flag sets after current stays below level for the time.
// RULE_10: Zero-current flag stays on at least 0.1 s after it turns on.
// RULE_11: Zero-current flag clears 0.1 s after current recovers to level.
// RULE_12: Function code 13 or 113 puts the zero-current flag on a terminal.
// RULE_13: Zero-current level of zero disables zero-current detection.
// RULE_14: Current detection keeps working during auto-tuning.
// RULE_15: Current flags are published with about 0.1 s latency.
// RULE_16: Torque flag is on while torque is at or above the torque level.
// RULE_17: Torque detection is unavailable under plain V/F control.
// RULE_18: Function code 35 or 135 puts the torque flag on a terminal.
// RULE_19: User avoids very low zero level or very long zero time.
// RULE_20: Qualification timers restart when their condition drops early.
module current_torque_threshold_detect #(
   parameter int N_TERM = 7,
   parameter int TICK_CYCLES = current_torque_pkg::TICK_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire current_torque_pkg::meas_t meas,
   input wire current_torque_pkg::drive_state_t drive,
   output logic overcurrent_detect_flag,
   output logic zero_current_flag,
   output logic torque_reached_flag,
   output logic current_detect_fault,
   output logic [N_TERM-1:0] terminal_out
);

   // ==========================================================================
   // Parameter checks
   if (N_TERM < 1 || N_TERM > 8) begin : g_bad_term
      $error("N_TERM must lie between 1 and 8");
   end
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   // ==========================================================================
   // Functions
   function automatic logic [15:0] sat(input logic [31:0] v,
                                       input logic [15:0] lim);
      sat = (v[31:16] != 16'h0000 || v[15:0] > lim) ? lim : v[15:0];
   endfunction

   function automatic logic [15:0] tick_inc(input logic [15:0] c,
                                            input logic [15:0] lim);
      tick_inc = (c < lim) ? c + 16'h0001 : c;
   endfunction

   function automatic logic term_drive(input logic [7:0] code,
                                       input logic oc,
                                       input logic zc,
                                       input logic tq);
      case (code)
         current_torque_pkg::FUNC_OC_POS: term_drive = oc; // RULE_07
         current_torque_pkg::FUNC_OC_NEG: term_drive = !oc; // RULE_07
         current_torque_pkg::FUNC_ZC_POS: term_drive = zc; // RULE_12
         current_torque_pkg::FUNC_ZC_NEG: term_drive = !zc; // RULE_12
         current_torque_pkg::FUNC_TQ_POS: term_drive = tq; // RULE_18
         current_torque_pkg::FUNC_TQ_NEG: term_drive = !tq; // RULE_18
         default: term_drive = 1'b0;
      endcase
   endfunction

   // ==========================================================================
   // Bus slave
   logic [7:0] trip_select_r;
   logic [15:0] oc_level_r;
   logic [15:0] oc_delay_r;
   logic [15:0] zc_level_r;
   logic [15:0] zc_time_r;
   logic [15:0] oc_hold_r;
   logic [15:0] tq_level_r;
   logic [7:0] term_func_r [N_TERM];
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic fault_r;
   logic fault_clr;
   logic oc_pub_r;
   logic zc_pub_r;
   logic tq_r;
   logic access;
   logic [7:0] ofs;
   logic [31:0] rd_mux;

   assign access = hsel && hready && htrans[1];
   assign ofs = haddr[7:0];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign fault_clr = wr_pend_r && wr_addr_r == current_torque_pkg::STATUS_OFS
                      && hwdata[current_torque_pkg::ST_FAULT_BIT];

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (ofs)
         current_torque_pkg::TRIP_SELECT_OFS: rd_mux[7:0] = trip_select_r;
         current_torque_pkg::OC_LEVEL_OFS: rd_mux[15:0] = oc_level_r;
         current_torque_pkg::OC_DELAY_OFS: rd_mux[15:0] = oc_delay_r;
         current_torque_pkg::ZC_LEVEL_OFS: rd_mux[15:0] = zc_level_r;
         current_torque_pkg::ZC_TIME_OFS: rd_mux[15:0] = zc_time_r;
         current_torque_pkg::OC_HOLD_OFS: rd_mux[15:0] = oc_hold_r;
         current_torque_pkg::TQ_LEVEL_OFS: rd_mux[15:0] = tq_level_r;
         current_torque_pkg::STATUS_OFS: begin
            rd_mux[current_torque_pkg::ST_OC_BIT] = oc_pub_r;
            rd_mux[current_torque_pkg::ST_ZC_BIT] = zc_pub_r;
            rd_mux[current_torque_pkg::ST_TQ_BIT] = tq_r;
            rd_mux[current_torque_pkg::ST_FAULT_BIT] = fault_r;
         end
         default: begin
            for (int i = 0; i < N_TERM; i++) begin
               if (ofs == current_torque_pkg::TERM_FUNC_OFS + 8'(4 * i)) begin
                  rd_mux[7:0] = term_func_r[i];
               end
            end
         end
      endcase
   end

   // Read data is captured in the address phase so it stands from a flop.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         wr_pend_r <= access && hwrite;
         if (access) begin
            wr_addr_r <= ofs;
         end
         if (access && !hwrite) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // Out-of-range level, time and hold settings saturate rather than wrap.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_select_r <= current_torque_pkg::TRIP_RST;
         oc_level_r <= current_torque_pkg::OC_LEVEL_RST;
         oc_delay_r <= current_torque_pkg::OC_DELAY_RST;
         zc_level_r <= current_torque_pkg::ZC_LEVEL_RST;
         zc_time_r <= current_torque_pkg::ZC_TIME_RST;
         oc_hold_r <= current_torque_pkg::OC_HOLD_RST;
         tq_level_r <= current_torque_pkg::TQ_LEVEL_RST;
         for (int i = 0; i < N_TERM; i++) begin
            term_func_r[i] <= current_torque_pkg::FUNC_RST;
         end
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            current_torque_pkg::TRIP_SELECT_OFS:
               trip_select_r <= hwdata[7:0];
            current_torque_pkg::OC_LEVEL_OFS:
               oc_level_r <= sat(hwdata, current_torque_pkg::LEVEL_MAX); // RULE_01
            current_torque_pkg::OC_DELAY_OFS:
               oc_delay_r <= sat(hwdata, current_torque_pkg::TIME_MAX);
            current_torque_pkg::ZC_LEVEL_OFS:
               zc_level_r <= sat(hwdata, current_torque_pkg::LEVEL_MAX); // RULE_08
            current_torque_pkg::ZC_TIME_OFS:
               zc_time_r <= sat(hwdata, current_torque_pkg::TIME_MAX);
            current_torque_pkg::OC_HOLD_OFS: begin
               if (hwdata[15:0] == current_torque_pkg::HOLD_FOREVER &&
                   hwdata[31:16] == 16'h0000) begin
                  oc_hold_r <= current_torque_pkg::HOLD_FOREVER;
               end else begin
                  oc_hold_r <= sat(hwdata, current_torque_pkg::TIME_MAX);
               end
            end
            current_torque_pkg::TQ_LEVEL_OFS:
               tq_level_r <= sat(hwdata, current_torque_pkg::LEVEL_MAX);
            default: begin
               for (int i = 0; i < N_TERM; i++) begin
                  if (wr_addr_r ==
                      current_torque_pkg::TERM_FUNC_OFS + 8'(4 * i)) begin
                     term_func_r[i] <= hwdata[7:0];
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================================
   // Time base
   logic [31:0] tick_cnt_r;
   logic [7:0] upd_cnt_r;
   logic tick;
   logic update;

   assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);
   assign update = tick && upd_cnt_r == 8'(current_torque_pkg::UPDATE_TICKS - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_r <= 32'h0000_0000;
         upd_cnt_r <= 8'h00;
      end else begin
         tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
         if (update) begin
            upd_cnt_r <= 8'h00;
         end else if (tick) begin
            upd_cnt_r <= upd_cnt_r + 8'h01;
         end
      end
   end

   // ==========================================================================
   // Overcurrent detector
   typedef enum logic [1:0] {
      OC_OFF = 2'b01,
      OC_ON = 2'b10
   } oc_state_t;

   oc_state_t oc_state_r;
   logic [15:0] oc_qual_cnt_r;
   logic [15:0] oc_hold_cnt_r;
   logic oc_cond;
   logic oc_qual;
   logic oc_held;

   // Auto-tuning is deliberately not looked at: detection stays live.
   assign oc_cond = drive.running && meas.current > oc_level_r; // RULE_01 RULE_14
   assign oc_qual = oc_cond && oc_qual_cnt_r >= oc_delay_r; // RULE_02
   assign oc_held = oc_hold_r == current_torque_pkg::HOLD_FOREVER ||
                    oc_hold_cnt_r < oc_hold_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_qual_cnt_r <= 16'h0000;
      end else if (!oc_cond) begin
         oc_qual_cnt_r <= 16'h0000; // RULE_20
      end else if (tick) begin
         oc_qual_cnt_r <= tick_inc(oc_qual_cnt_r, current_torque_pkg::TIME_MAX);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_state_r <= OC_OFF;
         oc_hold_cnt_r <= 16'h0000;
      end else begin
         case (oc_state_r)
            OC_OFF: begin
               oc_hold_cnt_r <= 16'h0000;
               if (oc_qual) begin
                  oc_state_r <= OC_ON;
               end
            end
            OC_ON: begin
               if (tick) begin
                  oc_hold_cnt_r <= tick_inc(oc_hold_cnt_r, // RULE_03
                                            current_torque_pkg::TIME_MAX);
               end
               if (oc_hold_r == current_torque_pkg::HOLD_FOREVER) begin
                  if (drive.start) begin
                     oc_state_r <= OC_OFF; // RULE_04
                  end
               end else if (!oc_held && !oc_qual) begin
                  oc_state_r <= OC_OFF; // RULE_03
               end
            end
            default: oc_state_r <= OC_OFF;
         endcase
      end
   end

   // ==========================================================================
   // Zero-current detector
   typedef enum logic [1:0] {
      ZC_OFF = 2'b01,
      ZC_ON = 2'b10
   } zc_state_t;

   zc_state_t zc_state_r;
   logic [15:0] zc_qual_cnt_r;
   logic [15:0] zc_on_cnt_r;
   logic [15:0] zc_rec_cnt_r;
   logic zc_enabled;
   logic zc_cond;

   assign zc_enabled = zc_level_r != 16'h0000; // RULE_13
   assign zc_cond = drive.running && zc_enabled &&
                    meas.current < zc_level_r; // RULE_08 RULE_14

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         zc_qual_cnt_r <= 16'h0000;
      end else if (!zc_cond) begin
         zc_qual_cnt_r <= 16'h0000; // RULE_20
      end else if (tick) begin
         zc_qual_cnt_r <= tick_inc(zc_qual_cnt_r, current_torque_pkg::TIME_MAX);
      end
   end

   // Leaving the flag on while stopped keeps a brake applied; only recovery
   // of current or disabling the detector clears it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         zc_state_r <= ZC_OFF;
         zc_on_cnt_r <= 16'h0000;
         zc_rec_cnt_r <= 16'h0000;
      end else begin
         case (zc_state_r)
            ZC_OFF: begin
               zc_on_cnt_r <= 16'h0000;
               zc_rec_cnt_r <= 16'h0000;
               if (zc_cond && zc_qual_cnt_r >= zc_time_r) begin
                  zc_state_r <= ZC_ON; // RULE_09
               end
            end
            ZC_ON: begin
               if (tick) begin
                  zc_on_cnt_r <= tick_inc(zc_on_cnt_r, // RULE_10
                                          current_torque_pkg::ZC_MIN_ON_TICKS);
               end
               if (meas.current < zc_level_r) begin
                  zc_rec_cnt_r <= 16'h0000;
               end else if (tick) begin
                  zc_rec_cnt_r <= tick_inc(zc_rec_cnt_r, // RULE_11
                                           current_torque_pkg::ZC_OFF_TICKS);
               end
               if (!zc_enabled) begin
                  zc_state_r <= ZC_OFF; // RULE_13
               end else if (zc_on_cnt_r >= current_torque_pkg::ZC_MIN_ON_TICKS &&
                  zc_rec_cnt_r >= current_torque_pkg::ZC_OFF_TICKS) begin
                  zc_state_r <= ZC_OFF; // RULE_10 RULE_11
               end
            end
            default: zc_state_r <= ZC_OFF;
         endcase
      end
   end

   // ==========================================================================
   // Published flags and torque detector
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_pub_r <= 1'b0;
         zc_pub_r <= 1'b0;
      end else if (update) begin
         oc_pub_r <= oc_state_r == OC_ON; // RULE_15
         zc_pub_r <= zc_state_r == ZC_ON && zc_enabled; // RULE_15
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tq_r <= 1'b0;
      end else begin
         tq_r <= !drive.vf_control && meas.torque >= tq_level_r; // RULE_16 RULE_17
      end
   end

   // ==========================================================================
   // Trip logic
   logic oc_trip_eff_r;
   logic zc_trip_eff_r;
   logic sel_oc;
   logic sel_zc;

   assign sel_oc = trip_select_r == current_torque_pkg::TRIP_OC ||
                   trip_select_r == current_torque_pkg::TRIP_BOTH; // RULE_05
   assign sel_zc = trip_select_r == current_torque_pkg::TRIP_ZC ||
                   trip_select_r == current_torque_pkg::TRIP_BOTH; // RULE_05

   // A new selection is only adopted while its flag is off, so enabling a
   // trip never fires on a flag that is already on.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oc_trip_eff_r <= 1'b0;
         zc_trip_eff_r <= 1'b0;
      end else begin
         if (!oc_pub_r) begin
            oc_trip_eff_r <= sel_oc; // RULE_06
         end
         if (!zc_pub_r) begin
            zc_trip_eff_r <= sel_zc; // RULE_06
         end
      end
   end

   // Setting the fault wins over a software clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_r <= 1'b0;
      end else if ((oc_pub_r && oc_trip_eff_r) ||
                   (zc_pub_r && zc_trip_eff_r)) begin
         fault_r <= 1'b1; // RULE_05
      end else if (fault_clr) begin
         fault_r <= 1'b0;
      end
   end

   // ==========================================================================
   // Output terminals
   logic [N_TERM-1:0] term_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         term_r <= '0;
      end else begin
         for (int i = 0; i < N_TERM; i++) begin
            term_r[i] <= term_drive(term_func_r[i], oc_pub_r, zc_pub_r, tq_r);
         end
      end
   end

   assign terminal_out = term_r;
   assign overcurrent_detect_flag = oc_pub_r;
   assign zero_current_flag = zc_pub_r;
   assign torque_reached_flag = tq_r;
   assign current_detect_fault = fault_r;

endmodule

//--- tb_current_torque_threshold_detect.sv
// Self-checking bench for the current and torque detectors.
`timescale 1ns/100ps
module tb_current_torque_threshold_detect;
   typedef struct {string nm; logic [31:0] ex; logic [31:0] mk;} note_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic hready, hreadyout, oc, zc, tq, flt, brake_on, bus_err;
   logic [31:0] hrdata;
   logic [6:0] term;
   current_torque_pkg::meas_t meas = '0;
   current_torque_pkg::drive_state_t drv = '0;
   logic rd_ph = 1'b0;
   logic peek = 1'b0;
   logic [31:0] seed = 32'h89fce492;
   int err_count, total_checks, cyc;
   note_t q[$];
   note_t nt;
   wire logic [31:0] obs = 32'({bus_err, brake_on, term, flt, tq, zc, oc});
   assign hready = hreadyout;

   current_torque_threshold_detect #(.N_TERM(7), .TICK_CYCLES(10)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(bus_err),
      .meas(meas), .drive(drv), .overcurrent_detect_flag(oc),
      .zero_current_flag(zc), .torque_reached_flag(tq),
      .current_detect_fault(flt), .terminal_out(term));
   brake_model i_brake (.hclk(hclk), .hresetn(hresetn), .apply_cmd(term[2]),
      .engaged(brake_on));

   // =====================================================
   // Helpers
   initial begin
      forever #5 hclk = ~hclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] ex);
      total_checks++;
      if (seen !== ex) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      haddr <= 32'(a);
      htrans <= 2'b10;
      hwrite <= 1'b1;
      do @(posedge hclk); while (!hready);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (!hready);
   endtask
   // The read result is compared by the watcher at the data phase edge.
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      q.push_back('{nm, ex, 32'hffffffff});
      haddr <= 32'(a);
      htrans <= 2'b10;
      hwrite <= 1'b0;
      do @(posedge hclk); while (!hready);
      htrans <= 2'b00;
      rd_ph <= 1'b1;
      do @(posedge hclk); while (!hready);
      rd_ph <= 1'b0;
   endtask
   task automatic pk(input logic [31:0] ex, input logic [31:0] mk, input string nm);
      q.push_back('{nm, ex, mk});
      peek <= 1'b1;
      @(posedge hclk);
      peek <= 1'b0;
      @(posedge hclk);
   endtask
   task automatic wb(input int b, input logic v, input int n);
      for (int i = 0; i < n && obs[b] !== v; i++) @(posedge hclk);
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc > 40000) begin
         err_count++;
         tally_and_finish();
      end
      if ((rd_ph && hready) || peek) begin
         nt = q.pop_front();
         check(nt.nm, (peek ? obs : hrdata) & nt.mk, nt.ex);
      end
   end

   // =====================================================
   // Scenarios
   initial begin
      logic [31:0] rv [9];
      logic [7:0] codes [6];
      logic t;
      rv = '{32'h0, 32'h5dc, 32'h0, 32'h32, 32'h32, 32'ha, 32'h5dc, 32'h0, 32'h0};
      codes = '{8'h0c, 8'h70, 8'h0d, 8'h71, 8'h23, 8'h87};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 9; i++) rd(8'(4 * i), rv[i], "reset value");
      rd(8'h80, 32'h0, "unmapped");
      wr(8'h04, 32'h1388);
      rd(8'h04, 32'h0fa0, "level clamp");
      wr(8'h04, 32'h5dc);
      for (int i = 0; i < 6; i++) wr(8'h20 + 8'(4 * i), 32'(codes[i]));
      wr(8'h18, 32'h3e8);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         meas.torque <= (i == 0) ? 16'hffff : {5'h0, seed[10:0]};
         drv.vf_control <= (i > 9);
         t = (i <= 9) && (i == 0 || seed[10:0] >= 11'h3e8);
         repeat (2) @(posedge hclk);
         pk(32'h0a0 | (t ? 32'h104 : 32'h200), 32'h3f4, "torque");
      end
      wr(8'h08, 32'h1e);
      wr(8'h14, 32'h270f);
      drv.running <= 1'b1;
      meas.current <= 16'h07d0;
      repeat (250) @(posedge hclk);
      meas.current <= 16'h03e8;
      repeat (20) @(posedge hclk);
      meas.current <= 16'h07d0;
      repeat (250) @(posedge hclk);
      pk(32'h0, 32'h1, "early overcurrent");
      wb(0, 1'b1, 500);
      pk(32'h11, 32'h31, "overcurrent on");
      meas.current <= 16'h03e8;
      wr(8'h00, 32'h1);
      repeat (500) @(posedge hclk);
      pk(32'h1, 32'h9, "held without trip");
      rd(8'h1c, 32'h1, "status");
      drv.start <= 1'b1;
      @(posedge hclk);
      drv.start <= 1'b0;
      wb(0, 1'b0, 300);
      pk(32'h0, 32'h1, "off at start");
      meas.current <= 16'h07d0;
      wb(3, 1'b1, 600);
      pk(32'h9, 32'h9, "trip on overcurrent");
      meas.current <= 16'h03e8;
      wr(8'h14, 32'h28);
      wb(0, 1'b0, 800);
      wr(8'h00, 32'h0);
      wr(8'h1c, 32'h8);
      pk(32'h0, 32'h1008, "fault cleared");
      meas.current <= 16'h07d0;
      wb(0, 1'b1, 600);
      meas.current <= 16'h03e8;
      repeat (250) @(posedge hclk);
      pk(32'h1, 32'h1, "hold time");
      wb(0, 1'b0, 500);
      pk(32'h0, 32'h9, "off without trip");
      drv.autotuning <= 1'b1;
      wr(8'h10, 32'h5);
      wr(8'h00, 32'h0b);
      meas.current <= 16'h000a;
      wb(1, 1'b1, 400);
      repeat (8) @(posedge hclk);
      pk(32'h84a, 32'h8ca, "zero current and brake");
      meas.current <= 16'h0064;
      repeat (60) @(posedge hclk);
      pk(32'h2, 32'h2, "zero current lingers");
      wb(1, 1'b0, 300);
      pk(32'h0, 32'h2, "zero current off");
      wr(8'h1c, 32'h8);
      wr(8'h0c, 32'h0);
      meas.current <= 16'h0000;
      repeat (400) @(posedge hclk);
      pk(32'h0, 32'ha, "zero detect disabled");
      tally_and_finish();
   end
endmodule
